// [flg_pkg.sv]
// Package of constants for the fault log and fault event block
package flg_pkg;

    // Register byte offsets
    localparam logic [7:0] REG_CAP = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_LOG_BASE = 8'h08;
    localparam logic [7:0] REG_LOG_SIZE = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_EVT_CTL = 8'h14;
    localparam logic [7:0] REG_EVT_ADDR = 8'h18;
    localparam logic [7:0] REG_EVT_DATA = 8'h1C;
    localparam logic [7:0] REG_INDEX = 8'h20;
    localparam logic [7:0] REG_PRIM_FLAGS = 8'h24;

    // Capability bits
    localparam int CAP_MEMLOG = 0;
    localparam int CAP_COMPRESS = 1;

    // Command register bits
    localparam int CMD_MEMLOG_EN = 0;
    localparam int CMD_NEW_LOG = 1;

    // Fault status bits
    localparam int ST_PRIM_OVF = 0;
    localparam int ST_PRIM_PEND = 1;
    localparam int ST_LOG_OVF = 2;
    localparam int ST_LOG_PEND = 3;
    localparam int ST_IQE = 4;
    localparam int ST_ICE = 5;
    localparam int ST_ITE = 6;
    localparam int ST_PRO = 7;
    localparam int ST_W = 8;

    // Event control bits
    localparam int EC_PEND = 30;
    localparam int EC_MASK = 31;

    // Reset values
    localparam logic [31:0] EVT_CTL_RST = 32'h8000_0000;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;

    // AHB transfer type
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    // Memory write master states
    typedef enum logic [1:0] {FLG_IDLE, FLG_REC, FLG_MSG} flg_state_t;

endpackage : flg_pkg

// [flg_fault_log.sv]
// Fault log writer and fault event logic with an AHB-Lite register slave
//
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps

// Summary of operation
// - Memory log support is shown by a capability bit software can read.
// - Log base and size come from software-written log configuration registers.
// - Write index clears on new log command, advances per written record.
// - Each advance checks wrap against log size; wrap state clears on new log.
// - Optional duplicate drop by last source id, cleared on new log.
// - Register reads wait until earlier record writes are committed.
// - Fault arriving with log overflow set is discarded.
// - Non-duplicate fault with log full sets overflow and is discarded.
// - Otherwise record written; with pending set or index nonzero, only advance.
// - Record at index zero with pending clear sets pending and offers an event.
// - Events go out as a message write using event address and data registers.
// - Triggers: primary, log pending, queue error, completion, timeout, page overflow.
// - Trigger suppressed when any status flag already set; log flags only if active.
// - Unsuppressed event sets pending; sent and cleared unless masked.
// - Clearing mask while pending sends the message and clears pending.
// - All status clear while pending clears pending with no message.
// - Status and event control reads wait for earlier event messages.
// - Event messages bypass interrupt remapping, never translated.
// - Primary pending equals OR of all recording register fault flags.
module flg_fault_log
    import flg_pkg::*;
#(
    parameter int IDX_W = 16,
    parameter int SID_W = 16,
    parameter int REC_W = 32,
    parameter int NUM_FRR = 8,
    parameter bit HAS_COMPRESS = 1'b1
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // AHB-Lite register slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Fault reports from translation logic
    input wire logic fault_valid_in,
    input wire logic [SID_W-1:0] fault_sid_in,
    input wire logic [REC_W-1:0] fault_rec_in,
    output logic fault_ready_out,
    // Status from primary recording, invalidation and page-request logic
    input wire logic [NUM_FRR-1:0] frr_fault_in,
    input wire logic prim_ovf_set_in,
    input wire logic inval_queue_error_in,
    input wire logic inval_completion_error_in,
    input wire logic inval_timeout_error_in,
    input wire logic page_request_overflow_in,
    // Memory write path, also used for event messages
    output logic mem_wr_valid_out,
    output logic [31:0] mem_wr_addr_out,
    output logic [REC_W-1:0] mem_wr_data_out,
    output logic mem_wr_is_msg_out,
    output logic mem_wr_no_remap_out,
    input wire logic mem_wr_done_in
);

    localparam logic [IDX_W-1:0] IDX_ONE = {{(IDX_W-1){1'b0}}, 1'b1};
    localparam int BYTES_PER_REC = REC_W / 8;

    // Refuse widths the index readback and record path cannot serve
    if (REC_W % 32 != 0 || IDX_W < 2 || IDX_W > 16 || NUM_FRR < 1 || SID_W < 1)
    begin : g_bad_params
        $error("flg_fault_log: unsupported parameter values");
    end

    // Registers
    logic memlog_en;
    logic [31:0] log_base;
    logic [IDX_W-1:0] log_size;
    logic [ST_W-1:0] status;
    logic event_mask;
    logic event_held_pending;
    logic [31:0] evt_addr;
    logic [31:0] evt_data;
    logic [IDX_W-1:0] wr_index;
    logic wrapped;
    logic [SID_W-1:0] last_sid;
    logic last_sid_valid;
    flg_state_t state;
    logic msg_req;

    // Bus address phase capture
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;

    wire logic bus_take = hsel_in && hready_in && htrans_in[1];
    wire logic wr_acc = ph_valid && ph_write;
    wire logic rd_acc = ph_valid && !ph_write;
    wire logic new_log = wr_acc && ph_addr == REG_CMD && hwdata_in[CMD_NEW_LOG];

    // Read stalls until earlier record and message writes are done
    wire logic rd_stall = rd_acc && (state != FLG_IDLE || msg_req);
    // One wait state loads the read data flop, so data stands while ready is high
    logic rd_loaded;
    wire logic rd_wait = rd_acc && (!rd_loaded || rd_stall);

    assign hreadyout_out = !rd_wait;
    assign hresp_out = 1'b0;

    // A stall that starts after loading forces a fresh load of the read data
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            rd_loaded <= 1'b0;
        else
            rd_loaded <= rd_wait && !rd_stall;
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr <= 8'h00;
        end
        else if (hreadyout_out)
        begin
            ph_valid <= bus_take;
            ph_write <= hwrite_in;
            ph_addr <= {haddr_in[7:2], 2'b00};
        end
    end

    // Primary pending is a live OR of recording register flags
    wire logic prim_pend = |frr_fault_in;
    logic prim_pend_q;

    // Status set events
    logic [ST_W-1:0] set_ev;
    logic rec_ok;
    logic log_first;
    logic fault_take;
    logic is_dup;
    logic log_full_ev;

    // No record starts while a read waits, so a read is never overtaken
    assign fault_ready_out = state == FLG_IDLE && memlog_en && !new_log && !rd_acc;
    assign fault_take = fault_valid_in && fault_ready_out;
    assign is_dup = HAS_COMPRESS && last_sid_valid && last_sid == fault_sid_in;
    // Discard when overflow already set, drop duplicates, overflow when full
    assign rec_ok = fault_take && !status[ST_LOG_OVF] && !is_dup && !wrapped;
    assign log_full_ev = fault_take && !status[ST_LOG_OVF] && !is_dup && wrapped;
    assign log_first = rec_ok && !status[ST_LOG_PEND] && wr_index == '0;

    always_comb
    begin
        set_ev = '0;
        set_ev[ST_PRIM_OVF] = prim_ovf_set_in;
        set_ev[ST_PRIM_PEND] = prim_pend && !prim_pend_q;
        set_ev[ST_LOG_OVF] = log_full_ev;
        set_ev[ST_LOG_PEND] = log_first;
        set_ev[ST_IQE] = inval_queue_error_in;
        set_ev[ST_ICE] = inval_completion_error_in;
        set_ev[ST_ITE] = inval_timeout_error_in;
        set_ev[ST_PRO] = page_request_overflow_in;
    end

    // Trigger events and suppression by already set flags
    logic [ST_W-1:0] trig_mask;
    logic [ST_W-1:0] supp_mask;
    logic trigger;
    logic suppressed;
    always_comb
    begin
        trig_mask = '0;
        trig_mask[ST_PRIM_PEND] = 1'b1;
        trig_mask[ST_LOG_PEND] = 1'b1;
        trig_mask[ST_IQE] = 1'b1;
        trig_mask[ST_ICE] = 1'b1;
        trig_mask[ST_ITE] = 1'b1;
        trig_mask[ST_PRO] = 1'b1;
        supp_mask = '1;
        supp_mask[ST_LOG_OVF] = memlog_en;
        supp_mask[ST_LOG_PEND] = memlog_en;
    end
    assign trigger = |(set_ev & trig_mask);
    assign suppressed = |(status & supp_mask);

    // Status flags: hardware set wins over software write-one-to-clear
    wire logic [ST_W-1:0] sw_clr = (wr_acc && ph_addr == REG_STATUS) ? hwdata_in[ST_W-1:0] : '0;
    logic [ST_W-1:0] next_status;
    always_comb
    begin
        next_status = (status & ~sw_clr) | set_ev;
        next_status[ST_PRIM_PEND] = prim_pend;
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            status <= '0;
            prim_pend_q <= 1'b0;
        end
        else
        begin
            status <= next_status;
            prim_pend_q <= prim_pend;
        end
    end

    // Software configuration registers
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            memlog_en <= 1'b0;
            log_base <= ZERO32;
            log_size <= '0;
            evt_addr <= ZERO32;
            evt_data <= ZERO32;
        end
        else if (wr_acc)
        begin
            case (ph_addr)
                REG_CMD: memlog_en <= hwdata_in[CMD_MEMLOG_EN];
                REG_LOG_BASE: log_base <= hwdata_in;
                REG_LOG_SIZE: log_size <= hwdata_in[IDX_W-1:0];
                REG_EVT_ADDR: evt_addr <= hwdata_in;
                REG_EVT_DATA: evt_data <= hwdata_in;
                default: ;
            endcase
        end
    end

    // Log index, wrap state and last source id
    wire logic [IDX_W-1:0] idx_inc = wr_index + IDX_ONE;
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            wr_index <= '0;
            wrapped <= 1'b0;
            last_sid <= '0;
            last_sid_valid <= 1'b0;
        end
        else if (new_log)
        begin
            wr_index <= '0;
            wrapped <= 1'b0;
            last_sid_valid <= 1'b0;
        end
        else if (rec_ok)
        begin
            // Zero size is treated as a one-entry log
            wrapped <= idx_inc >= log_size;
            wr_index <= (idx_inc >= log_size) ? '0 : idx_inc;
            last_sid <= fault_sid_in;
            last_sid_valid <= 1'b1;
        end
    end

    // Event pending, mask and message request
    wire logic ctl_wr = wr_acc && ph_addr == REG_EVT_CTL;
    wire logic unmask = ctl_wr && !hwdata_in[EC_MASK] && event_mask;
    wire logic msg_sent = state == FLG_MSG && mem_wr_done_in;
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            event_mask <= EVT_CTL_RST[EC_MASK];
            event_held_pending <= EVT_CTL_RST[EC_PEND];
            msg_req <= 1'b0;
        end
        else
        begin
            if (ctl_wr)
                event_mask <= hwdata_in[EC_MASK];
            if (msg_sent)
                msg_req <= 1'b0;
            if (trigger && !suppressed)
            begin
                if (event_mask && !unmask)
                    event_held_pending <= 1'b1;
                else
                begin
                    event_held_pending <= 1'b0;
                    msg_req <= 1'b1;
                end
            end
            else if (unmask && event_held_pending)
            begin
                event_held_pending <= 1'b0;
                msg_req <= 1'b1;
            end
            else if (event_held_pending && next_status == '0)
                event_held_pending <= 1'b0;
        end
    end

    // Memory writer: one record or one message at a time
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state <= FLG_IDLE;
            mem_wr_valid_out <= 1'b0;
            mem_wr_addr_out <= ZERO32;
            mem_wr_data_out <= '0;
            mem_wr_is_msg_out <= 1'b0;
        end
        else
        begin
            case (state)
                FLG_IDLE:
                begin
                    if (rec_ok)
                    begin
                        // Record layout is the caller's REC_W-bit word
                        state <= FLG_REC;
                        mem_wr_valid_out <= 1'b1;
                        mem_wr_addr_out <= log_base + 32'(wr_index) * 32'(BYTES_PER_REC);
                        mem_wr_data_out <= fault_rec_in;
                        mem_wr_is_msg_out <= 1'b0;
                    end
                    else if (msg_req)
                    begin
                        state <= FLG_MSG;
                        mem_wr_valid_out <= 1'b1;
                        mem_wr_addr_out <= evt_addr;
                        mem_wr_data_out <= REC_W'(evt_data);
                        mem_wr_is_msg_out <= 1'b1;
                    end
                end
                FLG_REC, FLG_MSG:
                begin
                    if (mem_wr_done_in)
                    begin
                        state <= FLG_IDLE;
                        mem_wr_valid_out <= 1'b0;
                    end
                end
                default: state <= FLG_IDLE;
            endcase
        end
    end

    // Messages never pass through interrupt remapping
    assign mem_wr_no_remap_out = mem_wr_is_msg_out;

    // Read data mux
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            hrdata_out <= ZERO32;
        else if (bus_take && !hwrite_in && hreadyout_out)
            hrdata_out <= ZERO32;
        else if (rd_wait && !rd_stall)
        begin
            case (ph_addr)
                REG_CAP: hrdata_out <= (32'(HAS_COMPRESS) << CAP_COMPRESS)
                    | (32'h0000_0001 << CAP_MEMLOG);
                REG_CMD: hrdata_out <= 32'(memlog_en);
                REG_LOG_BASE: hrdata_out <= log_base;
                REG_LOG_SIZE: hrdata_out <= 32'(log_size);
                REG_STATUS: hrdata_out <= 32'(status);
                REG_EVT_CTL: hrdata_out <= {event_mask, event_held_pending, 30'h0000_0000};
                REG_EVT_ADDR: hrdata_out <= evt_addr;
                REG_EVT_DATA: hrdata_out <= evt_data;
                REG_INDEX: hrdata_out <= {15'h0000, wrapped, 16'(wr_index)};
                REG_PRIM_FLAGS: hrdata_out <= 32'(frr_fault_in);
                default: hrdata_out <= ZERO32;
            endcase
        end
    end

    // Log overflow keeps the writer from starting a record
    ovf_blocks_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        status[ST_LOG_OVF] && fault_take |=> state != FLG_REC)
        else $error("record written with overflow set");

    // New log command clears the index
    new_log_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        new_log |=> wr_index == '0 && !wrapped) else $error("index not cleared");

    // Masked unsuppressed event holds pending
    mask_holds_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        trigger && !suppressed && event_mask && !unmask |=> event_held_pending)
        else $error("masked event not held");

    // Unmask with pending asks for a message
    unmask_sends_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        unmask && event_held_pending && !(trigger && !suppressed) |=> msg_req && !event_held_pending)
        else $error("unmask did not send");

    // Reads are never answered during a write in flight
    read_order_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rd_acc && state != FLG_IDLE |-> !hreadyout_out) else $error("read passed write");

    // Full log sets overflow next cycle
    full_sets_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        log_full_ev |=> status[ST_LOG_OVF]) else $error("overflow not set");

    // First record raises log pending
    first_pend_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        log_first |=> status[ST_LOG_PEND]) else $error("log pending not set");

    // Primary pending tracks the flags one cycle later
    prim_or_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ##1 status[ST_PRIM_PEND] == $past(prim_pend)) else $error("primary pending wrong");

    // A started message uses the event address and carries the no-remap mark
    no_remap_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        state == FLG_IDLE && msg_req && !rec_ok
        |=> mem_wr_no_remap_out && mem_wr_addr_out == $past(evt_addr))
        else $error("message without bypass");

endmodule : flg_fault_log

// [flg_mem_model.sv]
// Memory and message sink model for the fault log write path
`timescale 1ns/100ps
module flg_mem_model
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Write path from the block
    input wire logic wr_valid_in,
    input wire logic [31:0] wr_addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_is_msg_in,
    input wire logic wr_no_remap_in,
    input wire logic slow_in,
    output logic wr_done_out,
    // Observed traffic
    output logic [31:0] n_rec_out,
    output logic [31:0] n_msg_out,
    output logic [31:0] last_addr_out,
    output logic [31:0] last_data_out,
    output logic last_no_remap_out
);
    logic [3:0] wait_cnt;

    // Commit after a short or long latency; slow mode keeps writes in flight
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            wr_done_out <= 1'b0;
            wait_cnt <= 4'h0;
            n_rec_out <= 32'h0000_0000;
            n_msg_out <= 32'h0000_0000;
            last_addr_out <= 32'h0000_0000;
            last_data_out <= 32'h0000_0000;
            last_no_remap_out <= 1'b0;
        end
        else if (wr_valid_in && !wr_done_out && wait_cnt >= (slow_in ? 4'h6 : 4'h0))
        begin
            wr_done_out <= 1'b1;
            wait_cnt <= 4'h0;
            last_addr_out <= wr_addr_in;
            last_data_out <= wr_data_in;
            last_no_remap_out <= wr_no_remap_in;
            n_msg_out <= n_msg_out + {31'h0000_0000, wr_is_msg_in};
            n_rec_out <= n_rec_out + {31'h0000_0000, !wr_is_msg_in};
        end
        else
        begin
            wr_done_out <= 1'b0;
            wait_cnt <= (wr_valid_in && !wr_done_out) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule : flg_mem_model

// [flg_fault_log_tb.sv]
// Self-checking bench for the fault log and fault event block
`timescale 1ns/100ps
module flg_fault_log_tb
    import flg_pkg::*;
;
    localparam logic [31:0] LPEND = 32'h0000_0008;
    logic clk_in, rstn_in = 0, hsel = 0, hwrite = 0, fvalid = 0, slow = 0, povf = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, frec = 0, rdata, hrdata;
    logic [15:0] fsid = 0;
    logic [7:0] frr = 0;
    logic [3:0] trig = 0;
    logic hready, hresp, fready, mvalid, mmsg, mnr, mdone, l_nr;
    logic [31:0] maddr, mdata, n_rec, n_msg, l_addr, l_data;
    int bad_count = 0, n_checks = 0, em = 0, k;

    // Design under test
    flg_fault_log i_flg_fault_log (.clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .fault_valid_in(fvalid),
        .fault_sid_in(fsid), .fault_rec_in(frec), .fault_ready_out(fready),
        .frr_fault_in(frr), .prim_ovf_set_in(povf), .inval_queue_error_in(trig[0]),
        .inval_completion_error_in(trig[1]), .inval_timeout_error_in(trig[2]),
        .page_request_overflow_in(trig[3]), .mem_wr_valid_out(mvalid),
        .mem_wr_addr_out(maddr), .mem_wr_data_out(mdata), .mem_wr_is_msg_out(mmsg),
        .mem_wr_no_remap_out(mnr), .mem_wr_done_in(mdone));

    // Memory side
    flg_mem_model i_flg_mem_model (.clk_in(clk_in), .rstn_in(rstn_in),
        .wr_valid_in(mvalid), .wr_addr_in(maddr), .wr_data_in(mdata),
        .wr_is_msg_in(mmsg), .wr_no_remap_in(mnr), .slow_in(slow), .wr_done_out(mdone),
        .n_rec_out(n_rec), .n_msg_out(n_msg), .last_addr_out(l_addr),
        .last_data_out(l_data), .last_no_remap_out(l_nr));

    // Clock
    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    task summarize;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask : chk

    // Sample ready off the edge so the result never races the clock
    task wait_hi(input int sel);
        int n;
        @(negedge clk_in);
        for (n = 0; n < 300 && (sel ? fready : hready) !== 1'b1; n++)
            @(negedge clk_in);
        if (n >= 300)
        begin
            bad_count++;
            summarize();
        end
        rdata = hrdata;
        @(posedge clk_in);
    endtask : wait_hi

    // One AHB-Lite single word transfer: address phase, then data phase
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {24'h00_0000, a};
        wait_hi(0);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_hi(0);
    endtask : bus

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, exp, rdata);
        chk("response", ZERO32, {31'h0, hresp});
    endtask : rd

    // Offer one fault and hold it until taken
    task fault(input logic [15:0] s, input logic [31:0] r);
        @(posedge clk_in);
        fvalid <= 1'b1;
        fsid <= s;
        frec <= r;
        wait_hi(1);
        fvalid <= 1'b0;
    endtask : fault

    task pulse(input logic [3:0] t, input logic p);
        @(posedge clk_in);
        trig <= t;
        povf <= p;
        @(posedge clk_in);
        trig <= 4'h0;
        povf <= 1'b0;
    endtask : pulse

    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk_in);
        rstn_in <= 1'b1;
        rd(REG_CAP, 32'h0000_0003, "capability");
        rd(REG_EVT_CTL, EVT_CTL_RST, "event ctl reset");
        wr(8'h30, 32'hFFFF_FFFF);
        rd(8'h30, ZERO32, "unmapped");
        wr(REG_LOG_BASE, 32'h0000_1000);
        wr(REG_LOG_SIZE, 32'h0000_0002);
        wr(REG_EVT_ADDR, 32'hFEE0_0000);
        wr(REG_EVT_DATA, 32'h0000_0041);
        wr(REG_CMD, 32'h0000_0003);
        rd(REG_INDEX, ZERO32, "index");
        slow <= 1'b1;
        // First record at index zero raises a held event
        fault(16'h0005, 32'hA1A1_0001);
        rd(REG_STATUS, LPEND, "status");
        chk("records", 32'h0000_0001, n_rec);
        chk("record addr", 32'h0000_1000, l_addr);
        chk("record data", 32'hA1A1_0001, l_data);
        rd(REG_EVT_CTL, 32'hC000_0000, "event ctl");
        wr(REG_EVT_CTL, ZERO32);
        em++;
        rd(REG_EVT_CTL, ZERO32, "event ctl");
        chk("messages", em, n_msg);
        chk("msg addr", 32'hFEE0_0000, l_addr);
        chk("msg data", 32'h0000_0041, l_data);
        chk("no remap", 32'h0000_0001, {31'h0, l_nr});
        // Duplicate, then wrap, then overflow and discard
        fault(16'h0005, 32'hA1A1_0002);
        rd(REG_INDEX, 32'h0000_0001, "index");
        fault(16'h0006, 32'hA1A1_0003);
        rd(REG_INDEX, 32'h0001_0000, "index");
        chk("record addr", 32'h0000_1004, l_addr);
        chk("messages", em, n_msg);
        fault(16'h0007, 32'hA1A1_0004);
        rd(REG_STATUS, 32'h0000_000C, "status");
        fault(16'h0008, 32'hA1A1_0005);
        rd(REG_INDEX, 32'h0001_0000, "index");
        chk("records", 32'h0000_0002, n_rec);
        wr(REG_STATUS, 32'h0000_000C);
        wr(REG_CMD, 32'h0000_0003);
        rd(REG_INDEX, ZERO32, "index");
        fault(16'h0006, 32'hA1A1_0006);
        em++;
        rd(REG_STATUS, LPEND, "status");
        chk("records", 32'h0000_0003, n_rec);
        chk("messages", em, n_msg);
        wr(REG_STATUS, 32'h0000_00FF);
        // Each status trigger sends one message unless a status flag is already set
        for (k = 0; k < 4; k++)
        begin
            pulse(4'h1 << k, 1'b0);
            em++;
            rd(REG_STATUS, 32'h0000_0010 << k, "status");
            chk("messages", em, n_msg);
            wr(REG_STATUS, 32'h0000_0010 << k);
        end
        pulse(4'h1, 1'b0);
        em++;
        pulse(4'h2, 1'b0);
        rd(REG_STATUS, 32'h0000_0030, "status");
        chk("messages", em, n_msg);
        wr(REG_STATUS, 32'h0000_0030);
        pulse(4'h0, 1'b1);
        pulse(4'h8, 1'b0);
        rd(REG_STATUS, 32'h0000_0081, "status");
        chk("messages", em, n_msg);
        wr(REG_STATUS, 32'h0000_0081);
        frr <= 8'h04;
        em++;
        rd(REG_STATUS, 32'h0000_0002, "status");
        chk("messages", em, n_msg);
        frr <= 8'h00;
        rd(REG_STATUS, ZERO32, "status");
        // Held event dropped once all status clears
        wr(REG_EVT_CTL, 32'h8000_0000);
        pulse(4'h4, 1'b0);
        rd(REG_EVT_CTL, 32'hC000_0000, "event ctl");
        wr(REG_STATUS, 32'h0000_0040);
        rd(REG_EVT_CTL, 32'h8000_0000, "event ctl");
        wr(REG_EVT_CTL, ZERO32);
        rd(REG_EVT_CTL, ZERO32, "event ctl");
        chk("messages", em, n_msg);
        // Log flags stop suppressing once memory logging is off
        fault(16'h0009, 32'hA1A1_0007);
        fault(16'h000A, 32'hA1A1_0008);
        wr(REG_CMD, ZERO32);
        pulse(4'h1, 1'b0);
        em++;
        rd(REG_STATUS, 32'h0000_0014, "status");
        chk("messages", em, n_msg);
        chk("records", 32'h0000_0004, n_rec);
        summarize();
    end
endmodule : flg_fault_log_tb
